//--- logic/fgc_pkg.sv
// Constants for the feedback gain and drive clamp register bank
package fgc_pkg;

    // ==========================================================
    // Register offsets
    localparam logic [7:0] FGC_ADDR_FEEDBACK_GAIN = 8'h23;
    localparam logic [7:0] FGC_ADDR_STEADY_LIMIT = 8'h24;
    localparam logic [7:0] FGC_ADDR_LIMIT_ONE = 8'h25;
    localparam logic [7:0] FGC_ADDR_LIMIT_TWO = 8'h26;

    // ==========================================================
    // Reset values
    localparam logic [7:0] FGC_RST_FEEDBACK_GAIN = 8'h36;
    localparam logic [7:0] FGC_RST_STEADY_LIMIT = 8'h64;
    localparam logic [7:0] FGC_RST_LIMIT_ONE = 8'h80;
    localparam logic [7:0] FGC_RST_LIMIT_TWO = 8'h00;
    localparam logic [7:0] FGC_RDATA_UNMAPPED = 8'h00;

    // ==========================================================
    // Field positions in the feedback gain register
    localparam int FGC_NOISE_GATE_BIT = 7;
    localparam int FGC_BRAKE_LSB = 4;
    localparam int FGC_BRAKE_MSB = 6;
    localparam int FGC_LOOP_LSB = 2;
    localparam int FGC_LOOP_MSB = 3;
    localparam int FGC_BEMF_LSB = 0;
    localparam int FGC_BEMF_MSB = 1;

    // ==========================================================
    // Settling gain codes
    typedef enum logic [1:0]
    {
        FGC_LOOP_VERY_SLOW,
        FGC_LOOP_SLOW,
        FGC_LOOP_FAST,
        FGC_LOOP_VERY_FAST
    } fgc_loop_gain_t;

    // ==========================================================
    // Back-EMF amplifier gain in hundredths, per code
    localparam logic [11:0] FGC_RES_GAIN_X100_0 = 12'h1F4;
    localparam logic [11:0] FGC_RES_GAIN_X100_1 = 12'h3E8;
    localparam logic [11:0] FGC_RES_GAIN_X100_2 = 12'h7D0;
    localparam logic [11:0] FGC_RES_GAIN_X100_3 = 12'hBB8;
    localparam logic [11:0] FGC_ECC_GAIN_X100_0 = 12'h022;
    localparam logic [11:0] FGC_ECC_GAIN_X100_1 = 12'h069;
    localparam logic [11:0] FGC_ECC_GAIN_X100_2 = 12'h0B6;
    localparam logic [11:0] FGC_ECC_GAIN_X100_3 = 12'h190;

endpackage

//--- logic/fgc_clamp_sel.sv
// Effective clamp selection and back-EMF gain lookup
module fgc_clamp_sel
(
    // Mode and status
    input wire logic i_actuator_ecc,
    input wire logic i_cal_active,
    input wire logic i_diag_active,
    input wire logic i_batt_below_one,
    input wire logic i_batt_below_two,
    input wire logic i_overdrive_phase,
    // Limits and back-EMF gain code
    input wire logic [7:0] i_overdrive_limit,
    input wire logic [7:0] i_steady_drive_limit,
    input wire logic [7:0] i_low_battery_overdrive_limit_one,
    input wire logic [7:0] i_low_battery_overdrive_limit_two,
    input wire logic [1:0] i_backemf_amp_gain,
    // Results
    output logic [7:0] o_active_overdrive_limit,
    output logic [7:0] o_drive_clamp,
    output logic [11:0] o_backemf_gain_x100
);

    // ==========================================================
    // Overdrive limit choice
    always_comb
    begin
        if (i_cal_active || i_diag_active)
        begin
            o_active_overdrive_limit = i_overdrive_limit;
        end
        else if (i_batt_below_two)
        begin
            o_active_overdrive_limit = i_low_battery_overdrive_limit_two;
        end
        else if (i_batt_below_one)
        begin
            o_active_overdrive_limit = i_low_battery_overdrive_limit_one;
        end
        else
        begin
            o_active_overdrive_limit = i_overdrive_limit;
        end
    end

    // ==========================================================
    // Clamp: steady limit only outside overdrive, never above the active limit
    always_comb
    begin
        if (i_overdrive_phase)
        begin
            o_drive_clamp = o_active_overdrive_limit;
        end
        else if (o_active_overdrive_limit < i_steady_drive_limit)
        begin
            o_drive_clamp = o_active_overdrive_limit;
        end
        else
        begin
            o_drive_clamp = i_steady_drive_limit;
        end
    end

    // ==========================================================
    // Gain meaning depends on actuator mode
    always_comb
    begin
        unique case (i_backemf_amp_gain)
            2'h0: o_backemf_gain_x100 = i_actuator_ecc ? fgc_pkg::FGC_ECC_GAIN_X100_0
                                                       : fgc_pkg::FGC_RES_GAIN_X100_0;
            2'h1: o_backemf_gain_x100 = i_actuator_ecc ? fgc_pkg::FGC_ECC_GAIN_X100_1
                                                       : fgc_pkg::FGC_RES_GAIN_X100_1;
            2'h2: o_backemf_gain_x100 = i_actuator_ecc ? fgc_pkg::FGC_ECC_GAIN_X100_2
                                                       : fgc_pkg::FGC_RES_GAIN_X100_2;
            2'h3: o_backemf_gain_x100 = i_actuator_ecc ? fgc_pkg::FGC_ECC_GAIN_X100_3
                                                       : fgc_pkg::FGC_RES_GAIN_X100_3;
        endcase
    end

endmodule

//--- logic/fgc_regs.sv
// Feedback gain and drive clamp register bank, top level
module fgc_regs
(
    // Clock and reset
    input wire logic i_sys_clk,
    input wire logic i_rst_n,

    // Register port behind the serial control interface
    input wire logic [7:0] i_reg_addr,
    input wire logic i_reg_wr,
    input wire logic i_reg_rd,
    input wire logic [7:0] i_reg_wdata,
    output logic [7:0] o_reg_rdata,
    output logic o_reg_rvalid,

    // Calibration result for the back-EMF gain
    input wire logic i_cal_gain_wr,
    input wire logic [1:0] i_cal_gain_code,

    // Operating status
    input wire logic i_actuator_ecc,
    input wire logic i_cal_active,
    input wire logic i_diag_active,
    input wire logic i_batt_below_one,
    input wire logic i_batt_below_two,
    input wire logic i_overdrive_phase,
    input wire logic i_drive_update,
    input wire logic [7:0] i_overdrive_limit,

    // Feedback configuration
    output logic o_noise_gate,
    output logic [2:0] o_brake_factor,
    output logic [1:0] o_loop_gain,
    output logic [1:0] o_backemf_amp_gain,
    output logic [11:0] o_backemf_gain_x100,

    // Clamp results
    output logic [7:0] o_active_overdrive_limit,
    output logic [7:0] o_drive_clamp
);

    // ==========================================================
    // State
    typedef struct packed
    {
        logic [7:0] feedback_gain_control;
        logic [7:0] rated_drive_limit;
        logic [7:0] low_battery_overdrive_limit_one;
        logic [7:0] low_battery_overdrive_limit_two;
        logic [7:0] rdata;
        logic rvalid;
        logic [7:0] sel_active;
        logic [7:0] sel_clamp;
        logic [11:0] sel_gain;
        logic [7:0] drive_clamp;
        logic [7:0] active_limit;
    } fgc_state_t;

    localparam fgc_state_t FGC_STATE_RESET = '{
        feedback_gain_control: fgc_pkg::FGC_RST_FEEDBACK_GAIN,
        rated_drive_limit: fgc_pkg::FGC_RST_STEADY_LIMIT,
        low_battery_overdrive_limit_one: fgc_pkg::FGC_RST_LIMIT_ONE,
        low_battery_overdrive_limit_two: fgc_pkg::FGC_RST_LIMIT_TWO,
        rdata: fgc_pkg::FGC_RDATA_UNMAPPED,
        rvalid: 1'b0,
        sel_active: fgc_pkg::FGC_RST_STEADY_LIMIT,
        sel_clamp: fgc_pkg::FGC_RST_STEADY_LIMIT,
        sel_gain: fgc_pkg::FGC_RES_GAIN_X100_2,
        drive_clamp: fgc_pkg::FGC_RST_STEADY_LIMIT,
        active_limit: fgc_pkg::FGC_RST_STEADY_LIMIT
    };

    fgc_state_t state_reg;
    fgc_state_t state_next;

    // ==========================================================
    // Reset release
    logic rst_meta_reg;
    logic rst_sync_reg;
    logic rst_n;

    always_ff @(posedge i_sys_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            rst_meta_reg <= 1'b0;
            rst_sync_reg <= 1'b0;
        end
        else
        begin
            rst_meta_reg <= 1'b1;
            rst_sync_reg <= rst_meta_reg;
        end
    end

    assign rst_n = rst_sync_reg;

    // ==========================================================
    // Selection network
    logic [7:0] comb_active_limit;
    logic [7:0] comb_clamp;
    logic [11:0] comb_gain_x100;

    fgc_clamp_sel u_clamp_sel
    (
        .i_actuator_ecc(i_actuator_ecc),
        .i_cal_active(i_cal_active),
        .i_diag_active(i_diag_active),
        .i_batt_below_one(i_batt_below_one),
        .i_batt_below_two(i_batt_below_two),
        .i_overdrive_phase(i_overdrive_phase),
        .i_overdrive_limit(i_overdrive_limit),
        .i_steady_drive_limit(state_reg.rated_drive_limit),
        .i_low_battery_overdrive_limit_one(state_reg.low_battery_overdrive_limit_one),
        .i_low_battery_overdrive_limit_two(state_reg.low_battery_overdrive_limit_two),
        .i_backemf_amp_gain(state_reg.feedback_gain_control[fgc_pkg::FGC_BEMF_MSB:fgc_pkg::FGC_BEMF_LSB]),
        .o_active_overdrive_limit(comb_active_limit),
        .o_drive_clamp(comb_clamp),
        .o_backemf_gain_x100(comb_gain_x100)
    );

    // ==========================================================
    // Decode
    logic wr_feedback;
    logic wr_steady;
    logic wr_limit_one;
    logic wr_limit_two;

    assign wr_feedback = i_reg_wr && (i_reg_addr == fgc_pkg::FGC_ADDR_FEEDBACK_GAIN);
    assign wr_steady = i_reg_wr && (i_reg_addr == fgc_pkg::FGC_ADDR_STEADY_LIMIT);
    assign wr_limit_one = i_reg_wr && (i_reg_addr == fgc_pkg::FGC_ADDR_LIMIT_ONE);
    assign wr_limit_two = i_reg_wr && (i_reg_addr == fgc_pkg::FGC_ADDR_LIMIT_TWO);

    // ==========================================================
    // Next state
    always_comb
    begin
        state_next = state_reg;
        state_next.rvalid = 1'b0;

        // Host write covers every field, loop gain and back-EMF gain included
        if (wr_feedback)
        begin
            state_next.feedback_gain_control = i_reg_wdata;
        end
        else if (i_cal_gain_wr)
        begin
            // Host write in the same cycle wins; the host had the last word
            state_next.feedback_gain_control[fgc_pkg::FGC_BEMF_MSB:fgc_pkg::FGC_BEMF_LSB] =
                i_cal_gain_code;
        end

        if (wr_steady)
        begin
            state_next.rated_drive_limit = i_reg_wdata;
        end

        if (wr_limit_one)
        begin
            state_next.low_battery_overdrive_limit_one = i_reg_wdata;
        end

        if (wr_limit_two)
        begin
            state_next.low_battery_overdrive_limit_two = i_reg_wdata;
        end

        // Read answers one cycle later; unmapped reads give zero
        if (i_reg_rd)
        begin
            state_next.rvalid = 1'b1;
            unique case (i_reg_addr)
                fgc_pkg::FGC_ADDR_FEEDBACK_GAIN: state_next.rdata = state_reg.feedback_gain_control;
                fgc_pkg::FGC_ADDR_STEADY_LIMIT: state_next.rdata = state_reg.rated_drive_limit;
                fgc_pkg::FGC_ADDR_LIMIT_ONE: state_next.rdata = state_reg.low_battery_overdrive_limit_one;
                fgc_pkg::FGC_ADDR_LIMIT_TWO: state_next.rdata = state_reg.low_battery_overdrive_limit_two;
                default: state_next.rdata = fgc_pkg::FGC_RDATA_UNMAPPED;
            endcase
        end

        // Selection tracked every cycle so status and limit changes are never missed
        state_next.sel_active = comb_active_limit;
        state_next.sel_clamp = comb_clamp;
        state_next.sel_gain = comb_gain_x100;

        // Applied clamp moves only on a drive update, keeping each drive sample consistent
        if (i_drive_update)
        begin
            state_next.drive_clamp = state_reg.sel_clamp;
            state_next.active_limit = state_reg.sel_active;
        end
    end

    // ==========================================================
    // State register
    always_ff @(posedge i_sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            state_reg <= FGC_STATE_RESET;
        end
        else
        begin
            state_reg <= state_next;
        end
    end

    // ==========================================================
    // Outputs
    assign o_reg_rdata = state_reg.rdata;
    assign o_reg_rvalid = state_reg.rvalid;
    assign o_noise_gate = state_reg.feedback_gain_control[fgc_pkg::FGC_NOISE_GATE_BIT];
    assign o_brake_factor = state_reg.feedback_gain_control[fgc_pkg::FGC_BRAKE_MSB:fgc_pkg::FGC_BRAKE_LSB];
    assign o_loop_gain = state_reg.feedback_gain_control[fgc_pkg::FGC_LOOP_MSB:fgc_pkg::FGC_LOOP_LSB];
    assign o_backemf_amp_gain = state_reg.feedback_gain_control[fgc_pkg::FGC_BEMF_MSB:fgc_pkg::FGC_BEMF_LSB];
    assign o_backemf_gain_x100 = state_reg.sel_gain;
    assign o_active_overdrive_limit = state_reg.active_limit;
    assign o_drive_clamp = state_reg.drive_clamp;

endmodule

//--- verif/fgc_regs_chk.sv
// Assertion checker for the feedback gain and drive clamp register bank
module fgc_regs_chk
(
    // Clock, reset and register port
    input wire logic i_sys_clk,
    input wire logic i_rst_n,
    input wire logic [7:0] i_reg_addr,
    input wire logic i_reg_wr,
    input wire logic i_reg_rd,
    input wire logic [7:0] i_reg_wdata,
    input wire logic [7:0] o_reg_rdata,
    input wire logic o_reg_rvalid,
    // Status and results
    input wire logic i_cal_gain_wr,
    input wire logic [1:0] i_cal_gain_code,
    input wire logic i_actuator_ecc,
    input wire logic i_cal_active,
    input wire logic i_diag_active,
    input wire logic i_overdrive_phase,
    input wire logic i_drive_update,
    input wire logic [7:0] i_overdrive_limit,
    input wire logic o_noise_gate,
    input wire logic [2:0] o_brake_factor,
    input wire logic [1:0] o_loop_gain,
    input wire logic [1:0] o_backemf_amp_gain,
    input wire logic [11:0] o_backemf_gain_x100,
    input wire logic [7:0] o_active_overdrive_limit,
    input wire logic [7:0] o_drive_clamp
);
    timeunit 1ns;
    timeprecision 1ps;
    // ==========================================================
    // Gain in hundredths, indexed by mode and code
    localparam logic [11:0] GTAB [8] = '{12'h1F4, 12'h3E8, 12'h7D0, 12'hBB8, 12'h022, 12'h069, 12'h0B6, 12'h190};
    logic mapped;
    assign mapped = (i_reg_addr >= 8'h23) && (i_reg_addr <= 8'h26);
    default clocking @(posedge i_sys_clk);
    endclocking
    // Design releases reset through two flops; wait until its state is live and one sample old
    logic [3:0] rst_hist;
    always_ff @(posedge i_sys_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            rst_hist <= 4'h0;
        end
        else
        begin
            rst_hist <= {rst_hist[2:0], 1'b1};
        end
    end
    default disable iff (!rst_hist[3]);

    // ==========================================================
    // Properties
    a_read_answer: assert property (i_reg_rd ##1 !i_reg_rd |-> o_reg_rvalid ##1 !o_reg_rvalid)
        else $error("read answer pulse wrong");
    a_unmapped_read: assert property (i_reg_rd && !mapped |=> o_reg_rdata == 8'h00)
        else $error("unmapped read not zero");
    a_gain_fields: assert property (i_reg_wr && i_reg_addr == 8'h23 |=>
        {o_noise_gate, o_brake_factor, o_loop_gain, o_backemf_amp_gain} == $past(i_reg_wdata))
        else $error("gain register write lost");
    a_cal_write: assert property (i_cal_gain_wr && !(i_reg_wr && i_reg_addr == 8'h23) |=>
        o_backemf_amp_gain == $past(i_cal_gain_code))
        else $error("calibration gain not taken");
    a_gain_table: assert property (o_backemf_gain_x100 == GTAB[{$past(i_actuator_ecc), $past(o_backemf_amp_gain)}])
        else $error("back-EMF gain value wrong");
    a_clamp_hold: assert property (!$past(i_drive_update) |-> $stable(o_drive_clamp) && $stable(o_active_overdrive_limit))
        else $error("clamp moved without drive update");
    a_safe_limits: assert property (i_drive_update && ($past(i_cal_active) || $past(i_diag_active)) |=>
        o_active_overdrive_limit == $past(i_overdrive_limit, 2))
        else $error("low-battery limit used in calibration");
    a_steady_min: assert property ($past(i_drive_update) && !$past(i_overdrive_phase, 2) |->
        o_drive_clamp <= o_active_overdrive_limit)
        else $error("steady clamp above active limit");
    a_overdrive_pass: assert property ($past(i_drive_update) && $past(i_overdrive_phase, 2) |->
        o_drive_clamp == o_active_overdrive_limit)
        else $error("steady limit applied during overdrive");
    c_cal_write: cover property (i_cal_gain_wr);
    c_unmapped: cover property (i_reg_rd && !mapped);
    c_safe_tick: cover property (i_drive_update && i_cal_active);
endmodule

bind fgc_regs fgc_regs_chk u_chk (.*);

//--- verif/fgc_regs_bench.sv
// Self-checking bench for the feedback gain and drive clamp register bank
module fgc_regs_bench;
    timeunit 1ns;
    timeprecision 1ps;
    logic i_sys_clk, i_rst_n, i_reg_wr, i_reg_rd, i_cal_gain_wr, i_actuator_ecc, i_cal_active, i_diag_active;
    logic i_batt_below_one, i_batt_below_two, i_overdrive_phase, i_drive_update, o_reg_rvalid, o_noise_gate;
    logic [7:0] i_reg_addr, i_reg_wdata, o_reg_rdata, i_overdrive_limit, o_active_overdrive_limit, o_drive_clamp;
    logic [1:0] i_cal_gain_code, o_loop_gain, o_backemf_amp_gain;
    logic [2:0] o_brake_factor;
    logic [11:0] o_backemf_gain_x100;
    int n_mismatch = 0;
    int num_checks = 0;
    int cycles = 0;
    logic [7:0] reset_vals [4] = '{8'h36, 8'h64, 8'h80, 8'h00};
    logic [11:0] gain_tab [8] = '{12'h1F4, 12'h3E8, 12'h7D0, 12'hBB8, 12'h022, 12'h069, 12'h0B6, 12'h190};
    // Mode bits: calibration, diagnostics, below one, below two, overdrive phase
    logic [4:0] modes [9] = '{5'h00, 5'h04, 5'h06, 5'h02, 5'h16, 5'h0A, 5'h01, 5'h05, 5'h07};
    logic [7:0] clamps [9] = '{8'h50, 8'h30, 8'h20, 8'h20, 8'h50, 8'h50, 8'h60, 8'h30, 8'h20};
    logic [7:0] actives [9] = '{8'h60, 8'h30, 8'h20, 8'h20, 8'h60, 8'h60, 8'h60, 8'h30, 8'h20};

    fgc_regs dut (.*);

    initial
    begin
        i_sys_clk = 1'b0;
        forever #5 i_sys_clk = ~i_sys_clk;
    end

    // ==========================================================
    // Shared tasks
    task automatic check(input logic [11:0] seen, input logic [11:0] exp);
        num_checks++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("BAD t=%0t seen=%h expected=%h", $time, seen, exp);
        end
    endtask

    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        @(posedge i_sys_clk);
        i_reg_addr <= a;
        i_reg_wdata <= d;
        i_reg_wr <= 1'b1;
        @(posedge i_sys_clk);
        i_reg_wr <= 1'b0;
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
        @(posedge i_sys_clk);
        i_reg_addr <= a;
        i_reg_rd <= 1'b1;
        @(posedge i_sys_clk);
        i_reg_rd <= 1'b0;
        #1;
        check({11'h0, o_reg_rvalid}, 12'h001);
        check({4'h0, o_reg_rdata}, {4'h0, e});
    endtask

    // Inputs settle one cycle before the tick, as the clamp samples them a cycle early
    task automatic tick(input logic [4:0] m, input logic [7:0] e, input logic [7:0] ea);
        @(posedge i_sys_clk);
        {i_cal_active, i_diag_active, i_batt_below_one, i_batt_below_two, i_overdrive_phase} <= m;
        @(posedge i_sys_clk);
        i_drive_update <= 1'b1;
        @(posedge i_sys_clk);
        i_drive_update <= 1'b0;
        #1;
        check({4'h0, o_drive_clamp}, {4'h0, e});
        check({4'h0, o_active_overdrive_limit}, {4'h0, ea});
    endtask

    task automatic complete_run;
        $display("checks %0d mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    always @(posedge i_sys_clk)
    begin
        cycles++;
        if (cycles == 3000)
        begin
            n_mismatch++;
            complete_run();
        end
    end

    // ==========================================================
    // Main sequence
    initial
    begin
        {i_rst_n, i_reg_wr, i_reg_rd, i_cal_gain_wr, i_actuator_ecc, i_cal_active, i_diag_active} = '0;
        {i_batt_below_one, i_batt_below_two, i_overdrive_phase, i_drive_update} = '0;
        i_reg_addr = 8'h00;
        i_reg_wdata = 8'h00;
        i_cal_gain_code = 2'h0;
        i_overdrive_limit = 8'h60;
        repeat (8) @(posedge i_sys_clk);
        i_rst_n <= 1'b1;
        repeat (3) @(posedge i_sys_clk);
        for (int k = 0; k < 4; k++)
            rd_chk(8'h23 + k[7:0], reset_vals[k]);
        check({4'h0, o_noise_gate, o_brake_factor, o_loop_gain, o_backemf_amp_gain}, 12'h036);
        for (int k = 0; k < 4; k++)
        begin
            wr_reg(8'h23 + k[7:0], 8'hA5 ^ k[7:0]);
            rd_chk(8'h23 + k[7:0], 8'hA5 ^ k[7:0]);
        end
        wr_reg(8'h30, 8'hFF);
        rd_chk(8'h30, 8'h00);
        $display("test registers done");
        for (int k = 0; k < 8; k++)
        begin
            @(posedge i_sys_clk);
            i_actuator_ecc <= k[2];
            wr_reg(8'h23, {4'h3, k[1:0], k[1:0]});
            @(posedge i_sys_clk);
            #1;
            check(o_backemf_gain_x100, gain_tab[k]);
            check({10'h0, o_loop_gain}, {10'h0, k[1:0]});
        end
        $display("test gain codes done");
        wr_reg(8'h23, 8'h3A);
        @(posedge i_sys_clk);
        i_cal_active <= 1'b1;
        i_cal_gain_wr <= 1'b1;
        i_cal_gain_code <= 2'h1;
        @(posedge i_sys_clk);
        i_cal_active <= 1'b0;
        i_cal_gain_wr <= 1'b0;
        #1;
        check({10'h0, o_backemf_amp_gain}, 12'h001);
        check({10'h0, o_loop_gain}, 12'h002);
        wr_reg(8'h23, 8'h36);
        #1;
        check({10'h0, o_backemf_amp_gain}, 12'h002);
        $display("test calibration gain done");
        wr_reg(8'h24, 8'h50);
        wr_reg(8'h25, 8'h30);
        wr_reg(8'h26, 8'h20);
        for (int k = 0; k < 9; k++)
            tick(modes[k], clamps[k], actives[k]);
        @(posedge i_sys_clk);
        i_batt_below_two <= 1'b0;
        repeat (3) @(posedge i_sys_clk);
        #1;
        check({4'h0, o_drive_clamp}, 12'h020);
        check({4'h0, o_active_overdrive_limit}, 12'h020);
        wr_reg(8'h24, 8'h10);
        tick(5'h00, 8'h10, 8'h60);
        $display("test clamp selection done");
        @(posedge i_sys_clk);
        i_rst_n <= 1'b0;
        repeat (4) @(posedge i_sys_clk);
        i_rst_n <= 1'b1;
        repeat (3) @(posedge i_sys_clk);
        #1;
        check({4'h0, o_drive_clamp}, 12'h064);
        check(o_backemf_gain_x100, gain_tab[6]);
        rd_chk(8'h25, 8'h80);
        $display("test mid-run reset done");
        complete_run();
    end
endmodule
